// >>> core/itc_pkg.sv
`default_nettype none

package itc_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [10:0] IDX_TREF_ADDR = 11'h410;
  localparam logic [10:0] IDX_TREF_DATA = 11'h411;
  localparam logic [10:0] IDX_PERSIST   = 11'h412;
  localparam logic [10:0] IDX_BUSCTL    = 11'h413;
  localparam logic [7:0]  RST_BYTE      = 8'h00;

  // ==========================================================
  // Address register fields
  localparam int TYPE_HI = 7;
  localparam int TYPE_LO = 6;
  localparam int ID_HI   = 3;
  localparam int ID_LO   = 0;
  localparam logic [1:0] TYPE_RX_GRP = 2'h0;
  localparam logic [1:0] TYPE_TX_GRP = 2'h1;
  localparam logic [1:0] TYPE_TRL    = 2'h2;
  localparam logic [1:0] TYPE_DIV    = 2'h3;

  // ==========================================================
  // Timing source and divisor codes
  localparam logic [5:0] SRC_PORT_MAX = 6'h1F;
  localparam logic [5:0] SRC_SYSDIV   = 6'h20;
  localparam logic [5:0] SRC_REFCLK   = 6'h21;
  localparam logic [5:0] SRC_8K       = 6'h22;
  localparam logic [3:0] DIV_LINK     = 4'h0;
  localparam logic [3:0] DIV_ONE      = 4'h1;
  localparam logic [3:0] DIV_T1       = 4'h2;
  localparam logic [3:0] DIV_E1       = 4'h3;

  // ==========================================================
  // Persistence fields
  localparam int ALPHA_BIT = 6;
  localparam int BETA_HI   = 5;
  localparam int BETA_LO   = 3;
  localparam int GAMMA_HI  = 2;
  localparam int GAMMA_LO  = 0;
  localparam logic [2:0] PERSIST_MAX_CODE = 3'h4;

  // ==========================================================
  // Cell bus control fields
  localparam int BC_LEVEL1     = 6;
  localparam int BC_RXDATA_DRV = 5;
  localparam int BC_RXCLAV_INV = 4;
  localparam int BC_TXLAST4    = 3;
  localparam int BC_TXCLAV_ACT = 2;
  localparam int BC_CLAV_DRV   = 1;
  localparam int BC_LATE_SMP   = 0;
  localparam logic [2:0] SAMPLE_DELAY_BYTES = 3'h5;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    SRC_K_PORT, SRC_K_SYSDIV, SRC_K_REFCLK, SRC_K_8K, SRC_K_NONE
  } itc_src_e;

  typedef enum logic [2:0] {
    RATIO_LINK, RATIO_1_1, RATIO_192_193, RATIO_15_16, RATIO_RSVD
  } itc_ratio_e;

  typedef struct packed {
    logic port_sel;
    logic rx_xfer;
    logic tx_xfer;
    logic tx_last4;
    logic rx_avail;
    logic tx_avail;
  } itc_cellbus_in_s;

  typedef struct packed {
    logic rx_data_oe;
    logic rx_clav;
    logic rx_clav_oe;
    logic tx_clav;
    logic tx_clav_oe;
  } itc_cellbus_out_s;

endpackage : itc_pkg

`default_nettype wire

// >>> core/itc_cfg.sv
// Design decision made here: the APB slave port.
`default_nettype none

module itc_cfg #(
  parameter int NUM_GROUPS = 16,
  parameter int NUM_PORTS  = 32,
  parameter int ADDR_W     = 16
) (
  // APB slave
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [ADDR_W-1:0]         paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Timing selections
  output logic [NUM_GROUPS-1:0][5:0]     rx_grp_src_code,
  output logic [NUM_GROUPS-1:0][5:0]     tx_grp_src_code,
  output logic [1:0][5:0]                trl_src_code,
  output itc_pkg::itc_src_e              rx_grp_src_kind [NUM_GROUPS],
  output itc_pkg::itc_src_e              tx_grp_src_kind [NUM_GROUPS],
  output itc_pkg::itc_src_e              trl_src_kind [2],
  output itc_pkg::itc_ratio_e            grp_ratio [NUM_GROUPS],
  // Persistence counts
  output logic [1:0]                     alpha_count,
  output logic [2:0]                     beta_count,
  output logic [2:0]                     gamma_count,
  // Cell bus
  output logic                           level1_mode,
  input  wire itc_pkg::itc_cellbus_in_s  cb_in,
  output itc_pkg::itc_cellbus_out_s      cb_out,
  // Stuff rate sampling
  input  wire logic                      icp_xfer,
  input  wire logic                      payload_byte,
  output logic                           stuff_sample
);
  import itc_pkg::*;

  // ==========================================================
  // Elaboration checks
  if (NUM_GROUPS < 1 || NUM_GROUPS > 16) begin : g_bad_groups
    $error("NUM_GROUPS must be 1 to 16");
  end
  if (NUM_PORTS < 1 || NUM_PORTS > 32) begin : g_bad_ports
    $error("NUM_PORTS must be 1 to 32");
  end
  if (ADDR_W < 13 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must be 13 to 32");
  end

  // ==========================================================
  // Bus decode
  logic [10:0] idx;
  logic        mapped;
  logic        wr_acc;
  logic [7:0]  sel_r;
  logic [7:0]  persist_r;
  logic [7:0]  busctl_r;
  logic [5:0]  elem_r [4][16];
  logic [1:0]  sel_type;
  logic [3:0]  sel_id;
  logic [5:0]  elem_rd;

  assign idx      = paddr[12:2];
  assign mapped   = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:13] == '0) &&
                    (idx >= IDX_TREF_ADDR) && (idx <= IDX_BUSCTL);
  assign wr_acc   = psel && penable && pwrite && mapped;
  assign sel_type = sel_r[TYPE_HI:TYPE_LO];
  assign sel_id   = sel_r[ID_HI:ID_LO];
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;

  // Selected element view, masked by type
  always_comb begin
    elem_rd = elem_r[sel_type][sel_id];
    if (sel_type == TYPE_DIV) begin
      elem_rd = {2'h0, elem_rd[3:0]};
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (mapped ? idx : 11'h000)                          // Refused: zero
        IDX_TREF_ADDR: prdata <= {24'h00_0000, sel_r};
        IDX_TREF_DATA: prdata <= {26'h000_0000, elem_rd};
        IDX_PERSIST:   prdata <= {24'h00_0000, persist_r};
        IDX_BUSCTL:    prdata <= {24'h00_0000, busctl_r};
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Registers
  // Element selector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r <= RST_BYTE;
    end else if (wr_acc && idx == IDX_TREF_ADDR) begin
      sel_r <= {pwdata[7:6], 2'h0, pwdata[3:0]};
    end
  end

  // Indirect element store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int t = 0; t < 4; t++) begin
        for (int g = 0; g < 16; g++) begin
          elem_r[t][g] <= 6'h00;
        end
      end
    end else if (wr_acc && idx == IDX_TREF_DATA) begin
      if (sel_type == TYPE_DIV) begin
        elem_r[sel_type][sel_id] <= {2'h0, pwdata[3:0]};
      end else begin
        elem_r[sel_type][sel_id] <= pwdata[5:0];
      end
    end
  end

  // Persistence and cell bus control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      persist_r <= RST_BYTE;
      busctl_r  <= RST_BYTE;
    end else if (wr_acc && idx == IDX_PERSIST) begin
      persist_r <= {1'b0, pwdata[6:0]};
    end else if (wr_acc && idx == IDX_BUSCTL) begin
      busctl_r <= {1'b0, pwdata[6:0]};
    end
  end

  // ==========================================================
  // Timing source decode
  function automatic itc_src_e src_kind(input logic [5:0] c,
                                        input logic       trl);
    itc_src_e k;
    k = SRC_K_NONE;
    if (c <= SRC_PORT_MAX) begin
      if ({1'b0, c} < 7'(NUM_PORTS)) begin
        k = SRC_K_PORT;
      end
    end else if (c == SRC_SYSDIV) begin
      k = SRC_K_SYSDIV;
    end else if (c == SRC_REFCLK) begin
      k = SRC_K_REFCLK;
    end else if (trl && c == SRC_8K) begin
      k = SRC_K_8K;
    end
    return k;
  endfunction : src_kind

  // Per group decode
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
    assign rx_grp_src_code[g] = elem_r[TYPE_RX_GRP][g];
    assign tx_grp_src_code[g] = elem_r[TYPE_TX_GRP][g];
    assign rx_grp_src_kind[g] = src_kind(elem_r[TYPE_RX_GRP][g], 1'b0);
    assign tx_grp_src_kind[g] = src_kind(elem_r[TYPE_TX_GRP][g], 1'b0);
    // Divisor ratio
    always_comb begin
      case (elem_r[TYPE_DIV][g][3:0])
        DIV_LINK: grp_ratio[g] = RATIO_LINK;
        DIV_ONE:  grp_ratio[g] = RATIO_1_1;
        DIV_T1:   grp_ratio[g] = RATIO_192_193;
        DIV_E1:   grp_ratio[g] = RATIO_15_16;
        default:  grp_ratio[g] = RATIO_RSVD;
      endcase
    end
  end

  // Reference output decode
  for (genvar o = 0; o < 2; o++) begin : g_trl
    assign trl_src_code[o] = elem_r[TYPE_TRL][o];
    assign trl_src_kind[o] = src_kind(elem_r[TYPE_TRL][o], 1'b1);
  end

  // ==========================================================
  // Persistence counts, codes above 4 clamp to 5
  always_comb begin
    alpha_count = persist_r[ALPHA_BIT] ? 2'h2 : 2'h1;
    beta_count  = (persist_r[BETA_HI:BETA_LO] > PERSIST_MAX_CODE) ? 3'h5
                : persist_r[BETA_HI:BETA_LO] + 3'h1;
    gamma_count = (persist_r[GAMMA_HI:GAMMA_LO] > PERSIST_MAX_CODE) ? 3'h5
                : persist_r[GAMMA_HI:GAMMA_LO] + 3'h1;
  end

  assign level1_mode = busctl_r[BC_LEVEL1];

  // ==========================================================
  // Cell bus drive and cell-available levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cb_out <= '0;
    end else begin
      cb_out.rx_data_oe <= cb_in.port_sel || busctl_r[BC_RXDATA_DRV];
      cb_out.rx_clav_oe <= cb_in.port_sel || busctl_r[BC_CLAV_DRV];
      cb_out.tx_clav_oe <= cb_in.port_sel || busctl_r[BC_CLAV_DRV];
      if (cb_in.port_sel && cb_in.rx_xfer) begin
        cb_out.rx_clav <= !busctl_r[BC_RXCLAV_INV];
      end else begin
        cb_out.rx_clav <= cb_in.rx_avail;
      end
      if (cb_in.port_sel && cb_in.tx_xfer && cb_in.tx_last4 &&
          busctl_r[BC_TXLAST4]) begin
        cb_out.tx_clav <= cb_in.tx_avail;
      end else if (cb_in.port_sel && cb_in.tx_xfer) begin
        cb_out.tx_clav <= busctl_r[BC_TXCLAV_ACT];
      end else begin
        cb_out.tx_clav <= cb_in.tx_avail;
      end
    end
  end

  // ==========================================================
  // Stuff rate sample timing
  logic [2:0] byte_cnt_r;
  logic       waiting_r;
  logic       icp_d_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      icp_d_r    <= 1'b0;
      waiting_r  <= 1'b0;
      byte_cnt_r <= 3'h0;
    end else begin
      icp_d_r <= icp_xfer;
      if (icp_xfer) begin
        waiting_r  <= 1'b0;
        byte_cnt_r <= 3'h0;
      end else if (icp_d_r) begin
        waiting_r  <= 1'b1;
        byte_cnt_r <= 3'h0;
      end else if (waiting_r && payload_byte) begin
        if (byte_cnt_r == SAMPLE_DELAY_BYTES) begin
          waiting_r <= 1'b0;
        end
        byte_cnt_r <= byte_cnt_r + 3'h1;
      end
    end
  end

  // Sample strobe: during the cell, or on the sixth byte after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stuff_sample <= 1'b0;
    end else if (!busctl_r[BC_LATE_SMP]) begin
      stuff_sample <= icp_xfer;
    end else begin
      stuff_sample <= !icp_xfer && !icp_d_r && waiting_r && payload_byte &&
                      byte_cnt_r == SAMPLE_DELAY_BYTES;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb_chk @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_icp_end;
    icp_xfer ##1 !icp_xfer;
  endsequence

  sequence s_quiet_five;
    (!icp_xfer)[*5];
  endsequence

  chk_div_write_lands: assert property (
    wr_acc && idx == IDX_TREF_DATA && sel_type == TYPE_DIV
    |=> elem_r[$past(sel_type)][$past(sel_id)] == {2'h0, $past(pwdata[3:0])})
    else $error("divisor write not stored");
  chk_data_readback: assert property (
    psel && !penable && mapped && idx == IDX_TREF_DATA
    |=> prdata[5:0] == $past(elem_rd) && prdata[31:6] == '0)
    else $error("timing data readback wrong");
  chk_alpha_count: assert property (
    alpha_count == (persist_r[ALPHA_BIT] ? 2'h2 : 2'h1) && alpha_count != 2'h0)
    else $error("alpha count wrong");
  chk_beta_range: assert property (
    persist_r[BETA_HI:BETA_LO] <= PERSIST_MAX_CODE
    |-> beta_count == persist_r[BETA_HI:BETA_LO] + 3'h1)
    else $error("beta count wrong");
  chk_gamma_range: assert property (
    persist_r[GAMMA_HI:GAMMA_LO] <= PERSIST_MAX_CODE
    |-> gamma_count == persist_r[GAMMA_HI:GAMMA_LO] + 3'h1)
    else $error("gamma count wrong");
  chk_rx_tristate: assert property (
    !cb_in.port_sel && !busctl_r[BC_RXDATA_DRV] && $stable(busctl_r)
    |=> !cb_out.rx_data_oe)
    else $error("rx data driven while unselected");
  chk_clav_tristate: assert property (
    !cb_in.port_sel && !busctl_r[BC_CLAV_DRV] && $stable(busctl_r)
    |=> !cb_out.rx_clav_oe && !cb_out.tx_clav_oe)
    else $error("cell available driven while unselected");
  chk_rx_clav_xfer: assert property (
    cb_in.port_sel && cb_in.rx_xfer && $stable(busctl_r)
    |=> cb_out.rx_clav == !$past(busctl_r[BC_RXCLAV_INV]))
    else $error("rx cell available level wrong");
  chk_tx_clav_last4: assert property (
    cb_in.port_sel && cb_in.tx_xfer && cb_in.tx_last4 &&
    !busctl_r[BC_TXLAST4] && $stable(busctl_r)
    |=> cb_out.tx_clav == $past(busctl_r[BC_TXCLAV_ACT]))
    else $error("tx cell available not forced");
  chk_early_sample: assert property (
    !busctl_r[BC_LATE_SMP] && $stable(busctl_r[BC_LATE_SMP])
    |=> stuff_sample == $past(icp_xfer))
    else $error("early sample does not follow control cell");
  chk_late_no_early: assert property (
    busctl_r[BC_LATE_SMP] ##0 s_icp_end ##1 s_quiet_five
    |-> !stuff_sample)
    else $error("late sample fired too soon");

endmodule : itc_cfg

`default_nettype wire

// >>> tb/itc_atm_model.sv
`default_nettype none

module itc_atm_model
  import itc_pkg::*;
(
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // Cell bus toward the device
  output var itc_pkg::itc_cellbus_in_s cb_in
);
  logic [31:0] lfsr_r;

  // ==========================================================
  // Random bus activity, last-four flag only inside a transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_r <= 32'h0000_0007;
      cb_in  <= '0;
    end else begin
      lfsr_r <= {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1]};
      cb_in  <= {lfsr_r[0], lfsr_r[3], lfsr_r[5], lfsr_r[5] & lfsr_r[7],
                 lfsr_r[9], lfsr_r[11]};
    end
  end

endmodule : itc_atm_model

`default_nettype wire

// >>> tb/ima_timing_sync_utopia_cfg_tb_top.sv
`default_nettype none

module ima_timing_sync_utopia_cfg_tb_top;
  import itc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int NPORT = 4;
  logic psel, penable, pwrite, pready, pslverr, pclk, presetn;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd_v, seed;
  logic [15:0][5:0] rx_code, tx_code;
  logic [1:0][5:0] trl_code;
  itc_src_e rx_kind [16];
  itc_src_e tx_kind [16];
  itc_src_e trl_kind [2];
  itc_ratio_e ratio [16];
  logic [1:0] alpha;
  logic [2:0] beta, gamma;
  logic level1, icp_xfer, payload_byte, stuff_sample, err_v;
  itc_cellbus_in_s cb_in, prev;
  itc_cellbus_out_s cb_out;
  int bad_count, comparisons;

  itc_cfg #(.NUM_GROUPS(16), .NUM_PORTS(NPORT), .ADDR_W(16)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_grp_src_code(rx_code),
    .tx_grp_src_code(tx_code), .trl_src_code(trl_code),
    .rx_grp_src_kind(rx_kind), .tx_grp_src_kind(tx_kind),
    .trl_src_kind(trl_kind), .grp_ratio(ratio), .alpha_count(alpha),
    .beta_count(beta), .gamma_count(gamma), .level1_mode(level1),
    .cb_in(cb_in), .cb_out(cb_out), .icp_xfer(icp_xfer),
    .payload_byte(payload_byte), .stuff_sample(stuff_sample));

  itc_atm_model u_atm (.pclk(pclk), .presetn(presetn), .cb_in(cb_in));

  // ==========================================================
  // Clock, checking and closing
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // ==========================================================
  // APB master, request held until pready is seen high
  task automatic apb(input logic wr, input logic [10:0] idx,
                     input logic [7:0] d, input logic [1:0] lo = 2'b00);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {3'b000, idx, lo};
    pwdata  <= {24'h0000_00, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [10:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd_v, {24'h0000_00, exp});
    chk(32'(err_v), 32'h0000_0000);
  endtask : rd_chk

  // ==========================================================
  // Expected decodes
  function automatic itc_src_e kind_of(logic [1:0] t, logic [5:0] c);
    if (c <= SRC_PORT_MAX) return (c < NPORT) ? SRC_K_PORT : SRC_K_NONE;
    if (c == SRC_SYSDIV) return SRC_K_SYSDIV;
    if (c == SRC_REFCLK) return SRC_K_REFCLK;
    return (t == TYPE_TRL && c == SRC_8K) ? SRC_K_8K : SRC_K_NONE;
  endfunction : kind_of

  function automatic itc_cellbus_out_s cb_exp(itc_cellbus_in_s i,
                                              logic [7:0] b);
    logic sel;
    sel = i.port_sel;
    cb_exp.rx_data_oe = sel | b[BC_RXDATA_DRV];
    cb_exp.rx_clav_oe = sel | b[BC_CLAV_DRV];
    cb_exp.tx_clav_oe = sel | b[BC_CLAV_DRV];
    cb_exp.rx_clav = (sel & i.rx_xfer) ? !b[BC_RXCLAV_INV] : i.rx_avail;
    cb_exp.tx_clav = (sel & i.tx_xfer) ?
      ((i.tx_last4 & b[BC_TXLAST4]) ? i.tx_avail : b[BC_TXCLAV_ACT])
      : i.tx_avail;
  endfunction : cb_exp

  // ==========================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    test_done();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] v;
    logic [5:0] c;
    logic [3:0] id;
    seed = 32'd20;
    bad_count = 0;
    comparisons = 0;
    {psel, penable, pwrite, icp_xfer, payload_byte} = '0;
    paddr = '0;
    pwdata = '0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    chk(32'(cb_out), 32'h0000_0000);
    chk({alpha, beta, gamma}, {2'd1, 3'd1, 3'd1});
    presetn <= 1'b1;
    rd_chk(IDX_TREF_DATA, RST_BYTE);
    rd_chk(IDX_PERSIST, RST_BYTE);
    rd_chk(IDX_BUSCTL, RST_BYTE);
    // Unmapped and misaligned accesses are refused
    apb(1'b0, 11'h414, 8'h00);
    chk(32'(err_v), 32'h0000_0001);
    apb(1'b1, IDX_PERSIST, 8'h3F, 2'b01);
    chk(32'(err_v), 32'h0000_0001);
    rd_chk(IDX_PERSIST, RST_BYTE);
    // Indirect timing elements, every type, with SRC_SYSDIV, SRC_REFCLK, SRC_8K on the outputs and divisor codes 0 to 3
    for (int t = 0; t < 4; t++) begin
      for (int k = 0; k < 4; k++) begin
        id = (t == 2) ? 4'(rnd() & 1) : 4'(rnd());
        case (k)
          0: c = 6'(rnd() % NPORT);
          1: c = SRC_SYSDIV;
          2: c = SRC_REFCLK;
          default: c = (t == 2) ? SRC_8K : 6'(NPORT + rnd() % 28);
        endcase
        if (t == 3) c = 6'(k);
        apb(1'b1, IDX_TREF_ADDR, {2'(t), 2'b00, id});
        apb(1'b1, IDX_TREF_DATA, {2'b00, c});
        rd_chk(IDX_TREF_DATA, {2'b00, c});
        case (t)
          0: begin
            chk(rx_code[id], c);
            chk(rx_kind[id], kind_of(2'(t), c));
          end
          1: begin
            chk(tx_code[id], c);
            chk(tx_kind[id], kind_of(2'(t), c));
          end
          2: begin
            chk(trl_code[id[0]], c);
            chk(trl_kind[id[0]], kind_of(2'(t), c));
          end
          default: chk(ratio[id], itc_ratio_e'(3'(k)));
        endcase
      end
    end
    // Persistence codes, boundaries and a fixed sweep
    for (int i = 0; i < 8; i++) begin
      v = {1'b0, 1'(i), 3'(i % 5), 3'((i + 2) % 5)};
      apb(1'b1, IDX_PERSIST, v);
      rd_chk(IDX_PERSIST, v);
      chk({alpha, beta, gamma}, {2'(v[6]) + 2'd1, v[5:3] + 3'd1,
          v[2:0] + 3'd1});
    end
    // Cell bus control against random ATM-side traffic
    for (int i = 0; i < 10; i++) begin
      v = (i < 2) ? {1'b0, {7{i[0]}}} : (rnd() & 8'h7F);
      apb(1'b1, IDX_BUSCTL, v);
      rd_chk(IDX_BUSCTL, v);
      chk(32'(level1), 32'(v[BC_LEVEL1]));
      @(posedge pclk);
      #1 prev = cb_in;
      repeat (24) begin
        @(posedge pclk);
        #1 chk(32'(cb_out), 32'(cb_exp(prev, v)));
        prev = cb_in;
      end
    end
    // Stuff sampling during the control cell
    apb(1'b1, IDX_BUSCTL, 8'h00);
    @(posedge pclk) icp_xfer <= 1'b1;
    #1 chk(32'(stuff_sample), 32'h0000_0000);
    @(posedge pclk) icp_xfer <= 1'b0;
    #1 chk(32'(stuff_sample), 32'h0000_0001);
    @(posedge pclk);
    #1 chk(32'(stuff_sample), 32'h0000_0000);
    // Delayed sampling after more than five payload bytes
    apb(1'b1, IDX_BUSCTL, 8'h01);
    @(posedge pclk) icp_xfer <= 1'b1;
    @(posedge pclk) icp_xfer <= 1'b0;
    repeat (6) begin
      @(posedge pclk) payload_byte <= 1'b1;
      #1 chk(32'(stuff_sample), 32'h0000_0000);
    end
    @(posedge pclk) payload_byte <= 1'b0;
    #1 chk(32'(stuff_sample), 32'h0000_0001);
    @(posedge pclk);
    #1 chk(32'(stuff_sample), 32'h0000_0000);
    test_done();
  end

endmodule : ima_timing_sync_utopia_cfg_tb_top

`default_nettype wire
